// ==== pll_cfg_pkg.sv ====
// Register map, reset values and field layout of the synthesizer configuration bank.
// Assumes each word sits at byte address four times its index on the register port.
package pll_cfg_pkg;
    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 8;
    localparam int NUM_WORDS = 12;
    localparam int ACC_W     = 32;

    // Word indices
    localparam logic [5:0] IDX_N_HIGH    = 6'h22;
    localparam logic [5:0] IDX_N_LOW     = 6'h24;
    localparam logic [5:0] IDX_PFD_DLY   = 6'h25;
    localparam logic [5:0] IDX_DEN_HIGH  = 6'h26;
    localparam logic [5:0] IDX_DEN_LOW   = 6'h27;
    localparam logic [5:0] IDX_SEED_HIGH = 6'h28;
    localparam logic [5:0] IDX_SEED_LOW  = 6'h29;
    localparam logic [5:0] IDX_NUM_HIGH  = 6'h2a;
    localparam logic [5:0] IDX_NUM_LOW   = 6'h2b;
    localparam logic [5:0] IDX_OUT_CTRL  = 6'h2c;
    localparam logic [5:0] IDX_OUT_A_SRC = 6'h2d;
    localparam logic [5:0] IDX_OUT_B_SRC = 6'h2e;
    localparam logic [5:0] IDX_ACC_HIGH  = 6'h3e;
    localparam logic [5:0] IDX_ACC_LOW   = 6'h3f;

    // Position of each word in the storage array
    localparam int POS_N_HIGH = 0, POS_N_LOW = 1, POS_PFD_DLY = 2, POS_DEN_HIGH = 3,
                   POS_DEN_LOW = 4, POS_SEED_HIGH = 5, POS_SEED_LOW = 6, POS_NUM_HIGH = 7,
                   POS_NUM_LOW = 8, POS_OUT_CTRL = 9, POS_OUT_A_SRC = 10, POS_OUT_B_SRC = 11;

    localparam logic [5:0] WORD_IDX [NUM_WORDS] = '{
        IDX_N_HIGH, IDX_N_LOW, IDX_PFD_DLY, IDX_DEN_HIGH, IDX_DEN_LOW, IDX_SEED_HIGH,
        IDX_SEED_LOW, IDX_NUM_HIGH, IDX_NUM_LOW, IDX_OUT_CTRL, IDX_OUT_A_SRC, IDX_OUT_B_SRC};
    localparam logic [15:0] WORD_RESET [NUM_WORDS] = '{
        16'h0010, 16'h0070, 16'h0205, 16'hffff, 16'hffff, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h22a2, 16'hc622, 16'h07f0};

    // Field positions
    localparam int PFD_DLY_LSB     = 8;
    localparam int PFD_DLY_W       = 6;
    localparam int N_HIGH_W        = 3;
    localparam int N_W             = 19;
    localparam int LEVEL_W         = 6;
    localparam int OUT_A_LEVEL_LSB = 8;
    localparam int OUT_B_LEVEL_LSB = 0;
    localparam int OUT_B_PD_BIT    = 7;
    localparam int OUT_A_PD_BIT    = 6;
    localparam int MOD_RST_BIT     = 5;
    localparam int MOD_ORDER_LSB   = 0;
    localparam int MOD_ORDER_W     = 3;
    localparam int OUT_A_SRC_LSB   = 11;
    localparam int OUT_A_SRC_W     = 2;

    typedef enum logic [2:0]
    {
        ORDER_INTEGER = 3'h0,
        ORDER_FIRST   = 3'h1,
        ORDER_SECOND  = 3'h2,
        ORDER_THIRD   = 3'h3
    } mod_order_t;

    typedef enum logic [1:0]
    {
        SRC_CHANNEL_DIV = 2'h0,
        SRC_VCO         = 2'h1,
        SRC_UNUSED      = 2'h2,
        SRC_RESERVED    = 2'h3
    } out_src_t;
endpackage : pll_cfg_pkg

// ==== cfg_word.sv ====
// One configuration word with a fixed reset value.
// Assumes a one-cycle load strobe from the address decoder.
`timescale 1ns/100ps
module cfg_word #(
    parameter int           W         = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         clk_sys_i,  // System clock
    input  wire logic         reset_i,    // Async reset, active high
    input  wire logic         wr_en_i,    // Load strobe
    input  wire logic [W-1:0] wr_data_i,  // Load value
    output logic      [W-1:0] q_o         // Stored word
);
    typedef struct packed
    {
        logic [W-1:0] q;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        if (wr_en_i)
        begin
            st_nxt.q = wr_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r.q <= RESET_VAL;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q_o = st_r.q;
endmodule : cfg_word

// ==== frac_modulator.sv ====
// Fractional accumulator: loads the seed while held, then adds the numerator modulo denominator.
// Assumes run, seed, numerator and denominator come from registers on the same clock.
`timescale 1ns/100ps
module frac_modulator (
    input  wire logic        clk_sys_i,  // System clock
    input  wire logic        reset_i,    // Async reset, active high
    input  wire logic        run_i,      // Accumulate when high, load seed when low
    input  wire logic [31:0] seed_i,     // Starting state
    input  wire logic [31:0] num_i,      // Step per cycle
    input  wire logic [31:0] den_i,      // Modulus
    output logic      [31:0] acc_o,      // Accumulator state
    output logic             carry_o     // Overflow this cycle
);
    typedef struct packed
    {
        logic [31:0] acc;
        logic        carry;
    } state_t;

    state_t      st_r;
    state_t      st_nxt;
    logic [32:0] sum;

    always_comb
    begin
        st_nxt = st_r;
        sum    = {1'b0, st_r.acc} + {1'b0, num_i};
        if (!run_i)
        begin
            st_nxt.acc   = seed_i;
            st_nxt.carry = 1'b0;
        end
        else if (sum >= {1'b0, den_i})
        begin
            st_nxt.acc   = 32'(sum - {1'b0, den_i});
            st_nxt.carry = 1'b1;
        end
        else
        begin
            st_nxt.acc   = sum[31:0];
            st_nxt.carry = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign acc_o   = st_r.acc;
    assign carry_o = st_r.carry;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_seed_load;
        !run_i |=> acc_o == $past(seed_i);
    endproperty
    a_seed_load: assert property (p_seed_load)
        else $error("accumulator did not load the seed while held");

    property p_no_carry_held;
        !run_i [*2] |-> !carry_o;
    endproperty
    a_no_carry_held: assert property (p_no_carry_held)
        else $error("carry seen while modulator held in reset");

    c_carry: cover property (run_i ##1 carry_o);
endmodule : frac_modulator

// ==== fractional_pll_config_regs.sv ====
// Configuration register bank of a fractional-N synthesizer with a small fractional engine.
// Assumes a single-master register port: one-cycle strobes, read data one cycle later.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps

// Notes on behaviour
// - Six-bit phase detector delay, bits 13-8, reset 2
// - Denominator from two words, reset all ones
// - Numerator from two words, reset zero
// - Seed words give modulator starting state
// - Output A level field, reset 0x22
// - Output B level field, reset 0x22
// - Bit 7 powers down output B, reset set
// - Bit 6 powers down output A, reset clear
// - Bit 5 low holds modulator in reset
// - Order field: integer, first, second, third
// - Output A source: divider or VCO
// - Feedback divider is nineteen bits, two words
module fractional_pll_config_regs (
    input  wire logic        clk_sys_i,              // System clock, 125 MHz
    input  wire logic        reset_i,                // Async reset, active high
    input  wire logic [7:0]  addr_i,                 // Byte address
    input  wire logic [15:0] wr_data_i,              // Write data
    input  wire logic        wr_i,                   // Write strobe
    input  wire logic        rd_i,                   // Read strobe
    output logic      [15:0] rd_data_o,              // Read data, cycle after strobe
    output logic             rd_valid_o,             // Read data valid
    output logic      [5:0]  phase_detector_delay_o, // Phase detector delay
    output logic      [18:0] feedback_divider_o,     // Integer feedback divider
    output logic      [31:0] frac_denominator_o,     // Fractional denominator
    output logic      [31:0] frac_numerator_o,       // Fractional numerator
    output logic      [31:0] modulator_seed_o,       // Modulator seed
    output logic      [5:0]  out_a_level_o,          // Output A drive level
    output logic      [5:0]  out_b_level_o,          // Output B drive level
    output logic             out_a_powerdown_o,      // Output A powered down
    output logic             out_b_powerdown_o,      // Output B powered down
    output logic             modulator_reset_low_o,  // Modulator reset, active low
    output logic      [2:0]  modulator_order_o,      // Modulator order code
    output logic             integer_mode_o,         // Order code selects integer mode
    output logic             order_unused_o,         // Order code is an unused value
    output logic             modulator_running_o,    // Fractional engine advancing
    output logic      [1:0]  out_a_source_select_o,  // Output A source code
    output logic             out_a_from_divider_o,   // Output A fed by channel divider
    output logic             out_a_from_vco_o,       // Output A fed by VCO
    output logic             out_a_source_bad_o,     // Output A source code unusable
    output logic      [31:0] modulator_acc_o,        // Fractional engine state
    output logic             modulator_carry_o       // Fractional engine overflow
);
    typedef struct packed
    {
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        integer_mode;
        logic        order_unused;
        logic        mod_run;
        logic        a_from_div;
        logic        a_from_vco;
        logic        a_bad;
    } state_t;

    state_t                          st_r;
    state_t                          st_nxt;
    logic [15:0]                     word_q [pll_cfg_pkg::NUM_WORDS];
    logic [pll_cfg_pkg::NUM_WORDS-1:0] wr_hit;
    logic [31:0]                     acc;
    logic                            carry;
    logic [15:0]                     rd_mux;
    logic [2:0]                      order;
    logic [1:0]                      a_src;
    logic [15:0]                     ctrl_w;
    logic [15:0]                     src_w;

    // Word storage, one register per writable index; the accumulator indices have none
    genvar k;
    generate
        for (k = 0; k < pll_cfg_pkg::NUM_WORDS; k++)
        begin : g_word
            assign wr_hit[k] = wr_i && addr_i == {pll_cfg_pkg::WORD_IDX[k], 2'b00};
            cfg_word #(
                .W         (pll_cfg_pkg::DATA_W),
                .RESET_VAL (pll_cfg_pkg::WORD_RESET[k])
            ) u_word (
                .clk_sys_i (clk_sys_i),
                .reset_i   (reset_i),
                .wr_en_i   (wr_hit[k]),
                .wr_data_i (wr_data_i),
                .q_o       (word_q[k])
            );
        end
    endgenerate

    // Field views of the stored words
    assign ctrl_w                 = word_q[pll_cfg_pkg::POS_OUT_CTRL];
    assign src_w                  = word_q[pll_cfg_pkg::POS_OUT_A_SRC];
    assign phase_detector_delay_o = word_q[pll_cfg_pkg::POS_PFD_DLY][pll_cfg_pkg::PFD_DLY_LSB +:
                                    pll_cfg_pkg::PFD_DLY_W];
    assign feedback_divider_o     = {word_q[pll_cfg_pkg::POS_N_HIGH][pll_cfg_pkg::N_HIGH_W-1:0],
                                     word_q[pll_cfg_pkg::POS_N_LOW]};
    assign frac_denominator_o     = {word_q[pll_cfg_pkg::POS_DEN_HIGH],
                                     word_q[pll_cfg_pkg::POS_DEN_LOW]};
    assign frac_numerator_o       = {word_q[pll_cfg_pkg::POS_NUM_HIGH],
                                     word_q[pll_cfg_pkg::POS_NUM_LOW]};
    assign modulator_seed_o       = {word_q[pll_cfg_pkg::POS_SEED_HIGH],
                                     word_q[pll_cfg_pkg::POS_SEED_LOW]};
    assign out_a_level_o          = ctrl_w[pll_cfg_pkg::OUT_A_LEVEL_LSB +:
                                    pll_cfg_pkg::LEVEL_W];
    assign out_b_level_o          = src_w[pll_cfg_pkg::OUT_B_LEVEL_LSB +:
                                    pll_cfg_pkg::LEVEL_W];
    assign out_b_powerdown_o      = ctrl_w[pll_cfg_pkg::OUT_B_PD_BIT];
    assign out_a_powerdown_o      = ctrl_w[pll_cfg_pkg::OUT_A_PD_BIT];
    assign modulator_reset_low_o  = ctrl_w[pll_cfg_pkg::MOD_RST_BIT];
    assign order                  = ctrl_w[pll_cfg_pkg::MOD_ORDER_LSB +:
                                    pll_cfg_pkg::MOD_ORDER_W];
    assign modulator_order_o      = order;
    assign a_src                  = src_w[pll_cfg_pkg::OUT_A_SRC_LSB +:
                                    pll_cfg_pkg::OUT_A_SRC_W];
    assign out_a_source_select_o  = a_src;

    // Read multiplexer; unmapped and unaligned addresses read as zero
    always_comb
    begin
        rd_mux = '0;
        for (int i = 0; i < pll_cfg_pkg::NUM_WORDS; i++)
        begin
            if (addr_i == {pll_cfg_pkg::WORD_IDX[i], 2'b00})
            begin
                rd_mux = word_q[i];
            end
        end
        if (addr_i == {pll_cfg_pkg::IDX_ACC_HIGH, 2'b00})
        begin
            rd_mux = acc[31:16];
        end
        if (addr_i == {pll_cfg_pkg::IDX_ACC_LOW, 2'b00})
        begin
            rd_mux = acc[15:0];
        end
    end

    // Decode of order and source codes, registered
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.rd_valid = rd_i;
        st_nxt.rd_data  = rd_i ? rd_mux : 16'h0000;
        st_nxt.integer_mode = 1'b0;
        st_nxt.order_unused = 1'b0;
        case (order)
            pll_cfg_pkg::ORDER_INTEGER:
            begin
                st_nxt.integer_mode = 1'b1;
            end
            pll_cfg_pkg::ORDER_FIRST,
            pll_cfg_pkg::ORDER_SECOND,
            pll_cfg_pkg::ORDER_THIRD:
            begin
                st_nxt.integer_mode = 1'b0;
            end
            default:
            begin
                st_nxt.order_unused = 1'b1;
            end
        endcase
        // Engine only advances out of reset and in a fractional order
        st_nxt.mod_run = modulator_reset_low_o && !st_nxt.integer_mode
                         && !st_nxt.order_unused;
        st_nxt.a_from_div = 1'b0;
        st_nxt.a_from_vco = 1'b0;
        st_nxt.a_bad      = 1'b0;
        case (a_src)
            pll_cfg_pkg::SRC_CHANNEL_DIV:
            begin
                st_nxt.a_from_div = 1'b1;
            end
            pll_cfg_pkg::SRC_VCO:
            begin
                st_nxt.a_from_vco = 1'b1;
            end
            default:
            begin
                st_nxt.a_bad = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_r              <= '0;
            st_r.order_unused <= 1'b0;
            st_r.a_from_div   <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    frac_modulator u_mod (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .run_i     (st_r.mod_run),
        .seed_i    (modulator_seed_o),
        .num_i     (frac_numerator_o),
        .den_i     (frac_denominator_o),
        .acc_o     (acc),
        .carry_o   (carry)
    );

    assign rd_data_o            = st_r.rd_data;
    assign rd_valid_o           = st_r.rd_valid;
    assign integer_mode_o       = st_r.integer_mode;
    assign order_unused_o       = st_r.order_unused;
    assign modulator_running_o  = st_r.mod_run;
    assign out_a_from_divider_o = st_r.a_from_div;
    assign out_a_from_vco_o     = st_r.a_from_vco;
    assign out_a_source_bad_o   = st_r.a_bad;
    assign modulator_acc_o      = acc;
    assign modulator_carry_o    = carry;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    property p_pfd_write;
        wr_i && addr_i == {pll_cfg_pkg::IDX_PFD_DLY, 2'b00}
        |=> phase_detector_delay_o == $past(wr_data_i[13:8]);
    endproperty
    a_pfd_write: assert property (p_pfd_write)
        else $error("phase detector delay not taken from bits 13-8");

    property p_den_high;
        wr_i && addr_i == {pll_cfg_pkg::IDX_DEN_HIGH, 2'b00}
        |=> frac_denominator_o[31:16] == $past(wr_data_i) ##1 $stable(frac_denominator_o)
            || $past(wr_i);
    endproperty
    a_den_high: assert property (p_den_high)
        else $error("denominator upper half not updated");

    property p_num_low;
        wr_i && addr_i == {pll_cfg_pkg::IDX_NUM_LOW, 2'b00}
        |=> frac_numerator_o[15:0] == $past(wr_data_i)
            && frac_numerator_o[31:16] == $past(frac_numerator_o[31:16]);
    endproperty
    a_num_low: assert property (p_num_low)
        else $error("numerator lower half not updated alone");

    property p_a_level;
        wr_i && addr_i == {pll_cfg_pkg::IDX_OUT_CTRL, 2'b00}
        |=> out_a_level_o == $past(wr_data_i[13:8]) && out_a_powerdown_o == $past(wr_data_i[6]);
    endproperty
    a_a_level: assert property (p_a_level)
        else $error("output A level or power-down not taken");

    property p_b_level;
        wr_i && addr_i == {pll_cfg_pkg::IDX_OUT_A_SRC, 2'b00}
        |=> out_b_level_o == $past(wr_data_i[5:0])
            && out_a_source_select_o == $past(wr_data_i[12:11]);
    endproperty
    a_b_level: assert property (p_b_level)
        else $error("output B level or output A source not taken");

    property p_b_pd;
        wr_i && addr_i == {pll_cfg_pkg::IDX_OUT_CTRL, 2'b00}
        |=> out_b_powerdown_o == $past(wr_data_i[7]);
    endproperty
    a_b_pd: assert property (p_b_pd)
        else $error("output B power-down not taken from bit 7");

    property p_mod_hold;
        !modulator_reset_low_o |=> !modulator_running_o
            ##1 modulator_acc_o == $past(modulator_seed_o) || $past(wr_i);
    endproperty
    a_mod_hold: assert property (p_mod_hold)
        else $error("modulator advanced while held in reset");

    property p_order_int;
        modulator_order_o == 3'h0 |=> integer_mode_o && !modulator_running_o && !order_unused_o;
    endproperty
    a_order_int: assert property (p_order_int)
        else $error("integer order code not decoded");

    property p_order_bad;
        modulator_order_o > 3'h3 |=> order_unused_o && !integer_mode_o;
    endproperty
    a_order_bad: assert property (p_order_bad)
        else $error("unused order code not flagged");

    property p_src_vco;
        out_a_source_select_o == 2'h1 |=> out_a_from_vco_o && !out_a_from_divider_o;
    endproperty
    a_src_vco: assert property (p_src_vco)
        else $error("VCO source code not decoded");

    property p_n_read;
        rd_i && addr_i == {pll_cfg_pkg::IDX_N_LOW, 2'b00}
        |=> rd_valid_o && rd_data_o == feedback_divider_o[15:0];
    endproperty
    a_n_read: assert property (p_n_read)
        else $error("divider lower word read back wrong");

    property p_n_high;
        wr_i && addr_i == {pll_cfg_pkg::IDX_N_HIGH, 2'b00}
        |=> feedback_divider_o[18:16] == $past(wr_data_i[2:0]);
    endproperty
    a_n_high: assert property (p_n_high)
        else $error("divider upper part not taken from bits 2-0");

    property p_den_low;
        wr_i && addr_i == {pll_cfg_pkg::IDX_DEN_LOW, 2'b00}
        |=> frac_denominator_o[15:0] == $past(wr_data_i);
    endproperty
    a_den_low: assert property (p_den_low)
        else $error("denominator lower half not updated");

    property p_seed_high;
        wr_i && addr_i == {pll_cfg_pkg::IDX_SEED_HIGH, 2'b00}
        |=> modulator_seed_o[31:16] == $past(wr_data_i);
    endproperty
    a_seed_high: assert property (p_seed_high)
        else $error("seed upper half not updated");

    property p_ctrl_bits;
        wr_i && addr_i == {pll_cfg_pkg::IDX_OUT_CTRL, 2'b00}
        |=> modulator_reset_low_o == $past(wr_data_i[5])
            && modulator_order_o == $past(wr_data_i[2:0]);
    endproperty
    a_ctrl_bits: assert property (p_ctrl_bits)
        else $error("modulator reset or order not taken");

    property p_order_frac;
        modulator_reset_low_o && modulator_order_o inside {3'h1, 3'h2, 3'h3}
        |=> modulator_running_o && !integer_mode_o && !order_unused_o;
    endproperty
    a_order_frac: assert property (p_order_frac)
        else $error("fractional order code not decoded");

    property p_src_div;
        out_a_source_select_o == 2'h0
        |=> out_a_from_divider_o && !out_a_from_vco_o && !out_a_source_bad_o;
    endproperty
    a_src_div: assert property (p_src_div)
        else $error("divider source code not decoded");

    c_frac_run:   cover property (modulator_running_o && modulator_order_o == 3'h3);
    c_carry_out:  cover property (modulator_running_o ##1 modulator_carry_o);
    c_vco_source: cover property (out_a_from_vco_o && !out_a_powerdown_o);
    c_read_back:  cover property (wr_i ##2 rd_i ##1 rd_valid_o);
endmodule : fractional_pll_config_regs

// ==== tb_fractional_pll_config_regs.sv ====
// Self-checking bench for the synthesizer configuration bank.
// Drives the register port directly; expected values come from the register map.
`timescale 1ns/100ps
module tb_fractional_pll_config_regs;
    logic        clk_sys_i, reset_i, wr_i, rd_i;
    logic [7:0]  addr_i;
    logic [15:0] wr_data_i;
    logic [15:0] rd_data_o;
    logic        rd_valid_o, out_a_powerdown_o, out_b_powerdown_o, modulator_reset_low_o;
    logic        integer_mode_o, order_unused_o, modulator_running_o, modulator_carry_o;
    logic        out_a_from_divider_o, out_a_from_vco_o, out_a_source_bad_o;
    logic [5:0]  phase_detector_delay_o, out_a_level_o, out_b_level_o;
    logic [18:0] feedback_divider_o;
    logic [31:0] frac_denominator_o, frac_numerator_o, modulator_seed_o, modulator_acc_o;
    logic [2:0]  modulator_order_o;
    logic [1:0]  out_a_source_select_o;
    logic [31:0] e, prev;
    int          fail_count, total_checks;
    logic [7:0]  idx_tab [12] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
                                  8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e};
    logic [15:0] rst_tab [12] = '{16'h0010, 16'h0070, 16'h0205, 16'hffff, 16'hffff, 16'h0000,
                                  16'h0000, 16'h0000, 16'h0000, 16'h22a2, 16'hc622, 16'h07f0};

    fractional_pll_config_regs dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
        .rd_valid_o(rd_valid_o), .phase_detector_delay_o(phase_detector_delay_o),
        .feedback_divider_o(feedback_divider_o), .frac_denominator_o(frac_denominator_o),
        .frac_numerator_o(frac_numerator_o), .modulator_seed_o(modulator_seed_o),
        .out_a_level_o(out_a_level_o), .out_b_level_o(out_b_level_o),
        .out_a_powerdown_o(out_a_powerdown_o), .out_b_powerdown_o(out_b_powerdown_o),
        .modulator_reset_low_o(modulator_reset_low_o), .modulator_order_o(modulator_order_o),
        .integer_mode_o(integer_mode_o), .order_unused_o(order_unused_o),
        .modulator_running_o(modulator_running_o),
        .out_a_source_select_o(out_a_source_select_o),
        .out_a_from_divider_o(out_a_from_divider_o), .out_a_from_vco_o(out_a_from_vco_o),
        .out_a_source_bad_o(out_a_source_bad_o), .modulator_acc_o(modulator_acc_o),
        .modulator_carry_o(modulator_carry_o));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge clk_sys_i);
        wr_i      <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        chk(rd_valid_o, 1'b1);
        chk(rd_data_o, exp);
    endtask : rd

    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask : tick

    task automatic do_reset;
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1;
        chk(phase_detector_delay_o, 6'h02);
        chk(frac_denominator_o, 32'hffffffff);
        chk(frac_numerator_o, 32'h0);
        chk(modulator_seed_o, 32'h0);
        chk({out_a_level_o, out_b_level_o}, {6'h22, 6'h22});
        chk({out_b_powerdown_o, out_a_powerdown_o}, 2'b10);
        chk({modulator_reset_low_o, modulator_order_o}, {1'b1, 3'h2});
        chk(out_a_source_select_o, 2'h0);
        chk(feedback_divider_o, 19'h00070);
        for (int i = 0; i < 12; i++)
            rd({idx_tab[i][5:0], 2'b00}, rst_tab[i]);
    endtask : do_reset

    task automatic give_verdict;
        $display("Checks: %0d, mismatches: %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        #200000;
        fail_count++;
        give_verdict();
    end

    initial
    begin
        {wr_i, rd_i, addr_i, wr_data_i} = '0;
        fail_count   = 0;
        total_checks = 0;
        do_reset();
        // Multi-word values, numerator kept below denominator
        wr(8'h98, 16'h1234);
        wr(8'h9c, 16'h5678);
        wr(8'ha0, 16'h9abc);
        wr(8'ha4, 16'hdef0);
        wr(8'ha8, 16'h0123);
        wr(8'hac, 16'h4567);
        wr(8'h88, 16'h0005);
        wr(8'h90, 16'hbeef);
        chk(frac_denominator_o, 32'h12345678);
        chk(modulator_seed_o, 32'h9abcdef0);
        chk(frac_numerator_o, 32'h01234567);
        chk(feedback_divider_o, 19'h5beef);
        rd(8'ha4, 16'hdef0);
        wr(8'h94, {2'h2, 6'h3f, 8'h04});
        chk(phase_detector_delay_o, 6'h3f);
        for (int o = 0; o < 8; o++)
        begin
            wr(8'hb0, {2'b00, 6'h1f, o[1], o[0], 1'b1, 2'b00, o[2:0]});
            chk({out_a_level_o, modulator_order_o}, {6'h1f, o[2:0]});
            chk({out_b_powerdown_o, out_a_powerdown_o}, o[1:0]);
            tick();
            chk(integer_mode_o, o == 0);
            chk(order_unused_o, o > 3);
            chk(modulator_running_o, o > 0 && o < 4);
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(8'hb4, {3'h6, s[1:0], 5'h03, 6'h1f - s[5:0]});
            chk({out_a_source_select_o, out_b_level_o}, {s[1:0], 6'h1f - s[5:0]});
            tick();
            chk({out_a_from_divider_o, out_a_from_vco_o}, {s == 0, s == 1});
            chk(out_a_source_bad_o, s > 1);
        end
        // Unaligned, unmapped and read-only places
        wr(8'h95, 16'hffff);
        wr(8'h00, 16'hffff);
        wr(8'hf8, 16'h1234);
        rd(8'h95, 16'h0000);
        rd(8'h00, 16'h0000);
        rd(8'h94, {2'h2, 6'h3f, 8'h04});
        // Engine held in reset loads the seed, then steps by the numerator
        wr(8'ha0, 16'h0000);
        wr(8'ha4, 16'h0005);
        wr(8'h98, 16'h0000);
        wr(8'h9c, 16'h0010);
        wr(8'ha8, 16'h0000);
        wr(8'hac, 16'h0003);
        wr(8'hb0, 16'h2282);
        repeat (3) tick();
        chk(modulator_running_o, 1'b0);
        chk({modulator_carry_o, modulator_acc_o}, {1'b0, 32'h5});
        wr(8'hb0, 16'h22a2);
        for (int w = 0; w < 10 && modulator_running_o !== 1'b1; w++)
            tick();
        chk(modulator_running_o, 1'b1);
        repeat (2) tick();
        for (int k = 0; k < 8; k++)
        begin
            prev = modulator_acc_o;
            tick();
            e = prev + 32'h3;
            chk(modulator_carry_o, e >= 32'h10);
            if (e >= 32'h10)
                e = e - 32'h10;
            chk(modulator_acc_o, e);
        end
        rd(8'hf8, 16'h0000);
        @(posedge clk_sys_i);
        do_reset();
        give_verdict();
    end
endmodule : tb_fractional_pll_config_regs
